//--- hw/t1_tx_rate_pkg.sv
// Notes on behaviour
// - Two-bit rate select field resets to 00; its meaning depends on multiplex enable.
// - Rate 00 runs base 1.544 Mbit/s; serial clock pin is input or driven output.
// - In base rate the multiframe sync pin marks each superframe boundary.
// - In base rate the frame sync pin marks each frame; data pin carries payload.
// - Rate 01 runs 2.048 Mbit/s, clocked by the multiframe sync pin.
// - Rate 10 runs 4.096 Mbit/s, clocked by the multiframe sync pin.
// - Rate 11 runs 8.192 Mbit/s, clocked by the multiframe sync pin.
// - In high-speed rates a config bit makes frame sync mark frames or superframes.
// - Multiplex enable 0 uses the rate table; 1 selects multiplexed operation.
package t1_tx_rate_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] TX_IFACE_CTRL_ADDR = 16'h0120;
    localparam logic [15:0] SYNC_CFG_ADDR      = 16'h0109;
    localparam logic [15:0] CLK_DIR_ADDR       = 16'h0121;
    localparam logic [15:0] STATUS_ADDR        = 16'h0122;

    localparam int MUX_EN_BIT   = 2;
    localparam int SYNC_SF_BIT  = 5;
    localparam int CLK_DRV_BIT  = 0;

    localparam logic [7:0] TX_IFACE_CTRL_RESET = 8'h00;
    localparam logic [7:0] SYNC_CFG_RESET      = 8'h00;
    localparam logic [7:0] CLK_DIR_RESET       = 8'h00;

    typedef enum logic [1:0]
    {
        RATE_BASE = 2'b00,
        RATE_2048 = 2'b01,
        RATE_4096 = 2'b10,
        RATE_8192 = 2'b11
    } rate_t;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_FREQ_HZ  = 125_000_000;
    localparam int BASE_CLK_HZ  = 1_544_000;
    // Half period rounds down, so the driven clock runs slightly fast
    localparam int BASE_HALF_CYC = CLK_FREQ_HZ / (2 * BASE_CLK_HZ);
    localparam logic [5:0] BASE_HALF_LAST = 6'(BASE_HALF_CYC - 1);

endpackage

//--- hw/pin_sync.sv
`timescale 1ns/1ps
module pin_sync
(
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic pin,
    output logic      level,
    output logic      rise
);
    typedef struct packed
    {
        logic meta;
        logic level;
        logic prev;
    } sync_state_t;

    sync_state_t s_reg;
    sync_state_t s_next;

    // First stage feeds only the second; edges look at later stages
    always_comb
    begin
        s_next.meta  = pin;
        s_next.level = s_reg.meta;
        s_next.prev  = s_reg.level;
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            s_reg <= '0;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign level = s_reg.level;
    assign rise  = s_reg.level & ~s_reg.prev;
endmodule

//--- hw/t1_tx_backplane_rate_select.sv
`timescale 1ns/1ps
module t1_tx_backplane_rate_select
    import t1_tx_rate_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic [15:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        tx_serial_clk_pin_in,
    output logic             tx_serial_clk_pin_out,
    output logic             tx_serial_clk_pin_oe,
    input  wire logic        tx_multiframe_sync_pin,
    input  wire logic        tx_frame_sync_pin,
    input  wire logic        tx_serial_data_pin,
    output logic             tx_bit,
    output logic             tx_bit_valid,
    output logic             frame_mark,
    output logic             superframe_mark,
    output logic      [1:0]  rate_code
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed
    {
        logic [7:0] ctrl;
        logic [7:0] sync_cfg;
        logic [7:0] clk_dir;
        logic [5:0] div_cnt;
        logic       clk_out;
        logic       clk_oe;
        logic [7:0] rdata;
        logic       bit_q;
        logic       bit_valid;
        logic       frame_mk;
        logic       sframe_mk;
        logic       sync_prev;
        logic       msync_prev;
    } state_t;

    state_t s_reg;
    state_t s_next;

    logic serclk_s;
    logic serclk_rise;
    logic msync_s;
    logic msync_rise;
    logic sync_s;
    logic ser_s;
    logic mux_on;
    logic base_on;
    logic high_on;
    logic drive_clk;
    logic int_rise;
    logic data_edge;

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    pin_sync u_serclk
    (
        .clock   (clock),
        .sys_rst (sys_rst),
        .pin     (tx_serial_clk_pin_in),
        .level   (serclk_s),
        .rise    (serclk_rise)
    );

    pin_sync u_msync
    (
        .clock   (clock),
        .sys_rst (sys_rst),
        .pin     (tx_multiframe_sync_pin),
        .level   (msync_s),
        .rise    (msync_rise)
    );

    pin_sync u_sync
    (
        .clock   (clock),
        .sys_rst (sys_rst),
        .pin     (tx_frame_sync_pin),
        .level   (sync_s),
        .rise    ()
    );

    pin_sync u_ser
    (
        .clock   (clock),
        .sys_rst (sys_rst),
        .pin     (tx_serial_data_pin),
        .level   (ser_s),
        .rise    ()
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        s_next           = s_reg;
        s_next.rdata     = 8'h00;
        s_next.bit_valid = 1'b0;
        s_next.frame_mk  = 1'b0;
        s_next.sframe_mk = 1'b0;

        mux_on    = s_reg.ctrl[MUX_EN_BIT];
        base_on   = !mux_on && (rate_t'(s_reg.ctrl[1:0]) == RATE_BASE);
        high_on   = !mux_on && (rate_t'(s_reg.ctrl[1:0]) != RATE_BASE);
        drive_clk = base_on && s_reg.clk_dir[CLK_DRV_BIT];
        int_rise  = 1'b0;

        if (reg_wr)
        begin
            case (reg_addr)
                TX_IFACE_CTRL_ADDR: s_next.ctrl     = reg_wdata;
                SYNC_CFG_ADDR:      s_next.sync_cfg = reg_wdata;
                CLK_DIR_ADDR:       s_next.clk_dir  = reg_wdata;
                default:            s_next.ctrl     = s_reg.ctrl;
            endcase
        end

        if (reg_rd)
        begin
            case (reg_addr)
                TX_IFACE_CTRL_ADDR: s_next.rdata = s_reg.ctrl;
                SYNC_CFG_ADDR:      s_next.rdata = s_reg.sync_cfg;
                CLK_DIR_ADDR:       s_next.rdata = s_reg.clk_dir;
                STATUS_ADDR:        s_next.rdata = {4'h0, mux_on, drive_clk, high_on, base_on};
                default:            s_next.rdata = 8'h00;
            endcase
        end

        // Local 1.544 MHz source; held low while not driving the pin
        if (drive_clk)
        begin
            if (s_reg.div_cnt == BASE_HALF_LAST)
            begin
                s_next.div_cnt = 6'h00;
                s_next.clk_out = ~s_reg.clk_out;
                int_rise       = ~s_reg.clk_out;
            end
            else
            begin
                s_next.div_cnt = s_reg.div_cnt + 6'h01;
            end
        end
        else
        begin
            s_next.div_cnt = 6'h00;
            s_next.clk_out = 1'b0;
        end
        s_next.clk_oe = drive_clk;

        // High-speed rates clock data on the multiframe sync pin
        if (high_on)
        begin
            data_edge = msync_rise;
        end
        else if (base_on)
        begin
            data_edge = drive_clk ? int_rise : serclk_rise;
        end
        else
        begin
            // Multiplexed operation is handled elsewhere; capture idles
            data_edge = 1'b0;
        end

        if (data_edge)
        begin
            s_next.bit_q      = ser_s;
            s_next.bit_valid  = 1'b1;
            s_next.sync_prev  = sync_s;
            s_next.msync_prev = msync_s;
            if (sync_s && !s_reg.sync_prev)
            begin
                if (base_on || !s_reg.sync_cfg[SYNC_SF_BIT])
                begin
                    s_next.frame_mk = 1'b1;
                end
                else
                begin
                    s_next.sframe_mk = 1'b1;
                end
            end
            if (base_on && msync_s && !s_reg.msync_prev)
            begin
                s_next.sframe_mk = 1'b1;
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (sys_rst)
        begin
            s_reg          <= '0;
            s_reg.ctrl     <= TX_IFACE_CTRL_RESET;
            s_reg.sync_cfg <= SYNC_CFG_RESET;
            s_reg.clk_dir  <= CLK_DIR_RESET;
        end
        else
        begin
            s_reg <= s_next;
        end
    end

    assign reg_rdata             = s_reg.rdata;
    assign tx_serial_clk_pin_out = s_reg.clk_out;
    assign tx_serial_clk_pin_oe  = s_reg.clk_oe;
    assign tx_bit                = s_reg.bit_q;
    assign tx_bit_valid          = s_reg.bit_valid;
    assign frame_mark            = s_reg.frame_mk;
    assign superframe_mark       = s_reg.sframe_mk;
    assign rate_code             = s_reg.ctrl[1:0];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    ctrl_write_a: assert property (
        reg_wr && reg_addr == TX_IFACE_CTRL_ADDR
        |=> rate_code == $past(reg_wdata[1:0]))
        else $error("rate field write lost");
    clk_div_a: assert property (
        drive_clk && s_reg.div_cnt == BASE_HALF_LAST
        |=> tx_serial_clk_pin_out != $past(tx_serial_clk_pin_out))
        else $error("divider toggle wrong");
    clk_oe_a: assert property (
        tx_serial_clk_pin_oe |-> $past(base_on))
        else $error("clock driven outside base rate");
    base_sframe_a: assert property (
        base_on && data_edge && msync_s && !s_reg.msync_prev
        |=> superframe_mark)
        else $error("superframe missed");
    base_frame_a: assert property (
        frame_mark |-> tx_bit_valid)
        else $error("frame mark without data");
    rate_2048_a: assert property (
        high_on && s_reg.ctrl[1:0] == 2'b01 && msync_rise
        |=> tx_bit_valid && tx_bit == $past(ser_s))
        else $error("2048 capture wrong");
    rate_4096_a: assert property (
        high_on && s_reg.ctrl[1:0] == 2'b10 && msync_rise
        |=> tx_bit_valid && tx_bit == $past(ser_s))
        else $error("4096 capture wrong");
    rate_8192_a: assert property (
        high_on && s_reg.ctrl[1:0] == 2'b11 && msync_rise
        |=> tx_bit_valid && tx_bit == $past(ser_s))
        else $error("8192 capture wrong");
    sync_kind_a: assert property (
        frame_mark |-> $past(base_on || !s_reg.sync_cfg[SYNC_SF_BIT]))
        else $error("frame sync kind wrong");
    mux_idle_a: assert property (
        mux_on |=> !tx_bit_valid && !tx_serial_clk_pin_oe)
        else $error("capture active in multiplexed mode");

    base_data_c: cover property (base_on && tx_bit_valid && frame_mark);
    high_sframe_c: cover property (high_on && superframe_mark);
    mux_on_c: cover property (mux_on ##1 !mux_on);
endmodule

//--- tb/backplane_model.sv
`timescale 1ns/1ps
module backplane_model
(
    output logic sclk,
    output logic msync,
    output logic fsync,
    output logic sdata
);
    // ----------------------------------------
    // One bit per call
    // ----------------------------------------
    initial
    begin
        sclk  = 1'b0;
        msync = 1'b0;
        fsync = 1'b0;
        sdata = 1'b0;
    end
    // Clocks stand still between calls, as the far logic only pulses them per bit
    task automatic send(input logic d, input logic fs, input logic ms, input logic hs);
    begin
        sdata = d;
        fsync = fs;
        if (!hs)
            msync = ms;
        #40;
        if (hs)
            msync = 1'b1;
        else
            sclk = 1'b1;
        #40;
        if (hs)
            msync = 1'b0;
        sclk  = 1'b0;
        sdata = ~d; // Hold over: never leave the last bit showing
    end
    endtask
endmodule

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench
    import t1_tx_rate_pkg::*;
;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic        clk_out, clk_oe, tx_bit, tx_bit_valid, frame_mark, superframe_mark;
    logic [1:0]  rate_code;
    logic        sclk, msync, fsync, sdata;
    logic        watch = 1'b1;
    logic [2:0]  expq[$];
    int          num_errors = 0;
    int          tests_run = 0;
    int          n;
    logic [7:0]  seen_v;
    logic [7:0]  want_v;

    always #4 clock = ~clock;

    t1_tx_backplane_rate_select dut_u (.clock(clock), .sys_rst(sys_rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .tx_serial_clk_pin_in(sclk), .tx_serial_clk_pin_out(clk_out),
        .tx_serial_clk_pin_oe(clk_oe), .tx_multiframe_sync_pin(msync),
        .tx_frame_sync_pin(fsync), .tx_serial_data_pin(sdata), .tx_bit(tx_bit),
        .tx_bit_valid(tx_bit_valid), .frame_mark(frame_mark),
        .superframe_mark(superframe_mark), .rate_code(rate_code));
    backplane_model partner_u (.sclk(sclk), .msync(msync), .fsync(fsync), .sdata(sdata));

    // ----------------------------------------
    // Shared tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        tests_run++;
        if (seen !== want)
        begin
            num_errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask
    task automatic final_report();
        if (num_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic tick();
        @(posedge clock);
        #1;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clock);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] want);
        @(posedge clock);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clock);
        reg_rd   <= 1'b0;
        #1;
        check(reg_rdata, want);
    endtask
    task automatic wait_lvl(input logic v);
        for (n = 0; n < 200 && clk_out !== v; n++)
            tick();
        if (n == 200)
        begin
            num_errors++;
            final_report();
        end
    endtask
    // Session starts with both syncs low so stale edge history cannot make a mark
    task automatic bits(input logic hs, input logic sf);
        logic d, fs, ms, pf, pm, fe;
        pf = 1'b0;
        pm = 1'b0;
        for (int i = 0; i < 6; i++)
        begin
            d  = 1'($urandom);
            fs = (i == 2) || (i == 3);
            ms = (i == 4);
            fe = fs && !pf;
            expq.push_back(hs ? {d, fe && !sf, fe && sf} : {d, fe, ms && !pm});
            pf = fs;
            pm = ms;
            partner_u.send(d, fs, ms, hs);
        end
        repeat (10) tick();
        check(8'(expq.size()), 8'h00);
    endtask

    // Sampled mid-cycle, where the one-cycle pulses have settled
    always @(negedge clock)
        if (watch && tx_bit_valid === 1'b1)
        begin
            if (expq.size() == 0)
                check(8'h01, 8'h00);
            else
            begin
                seen_v = {5'h00, tx_bit, frame_mark, superframe_mark};
                want_v = {5'h00, expq.pop_front()};
                check(seen_v, want_v);
            end
        end

    initial
    begin
        #400000;
        num_errors++;
        final_report();
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial
    begin
        void'($urandom(31));
        repeat (8) @(posedge clock);
        sys_rst <= 1'b0;
        rd(TX_IFACE_CTRL_ADDR, TX_IFACE_CTRL_RESET);
        rd(SYNC_CFG_ADDR, SYNC_CFG_RESET);
        rd(CLK_DIR_ADDR, CLK_DIR_RESET);
        rd(16'h0000, 8'h00);
        rd(STATUS_ADDR, 8'h01);
        for (int r = 0; r < 4; r++)
            for (int sf = 0; sf < 2; sf++)
            begin
                wr(TX_IFACE_CTRL_ADDR, {6'h00, r[1:0]});
                wr(SYNC_CFG_ADDR, {2'h0, sf[0], 5'h00});
                rd(STATUS_ADDR, r == 0 ? 8'h01 : 8'h02);
                check({6'h00, rate_code}, 8'(r));
                check({7'h00, clk_oe}, 8'h00);
                bits(r != 0, sf[0]);
            end
        n = $urandom;
        wr(TX_IFACE_CTRL_ADDR, {n[7:3], 3'h0});
        // Status is read only: this write must leave the control field alone
        wr(STATUS_ADDR, 8'hFF);
        rd(TX_IFACE_CTRL_ADDR, {n[7:3], 3'h0});
        // Multiplexed operation idles capture on both clock pins
        wr(TX_IFACE_CTRL_ADDR, 8'h04);
        rd(STATUS_ADDR, 8'h08);
        for (int i = 0; i < 8; i++)
            partner_u.send(1'($urandom), 1'b1, 1'b1, i[0]);
        repeat (10) tick();
        // Driven serial clock: captures follow the divider, so the stream is not watched
        watch = 1'b0;
        wr(TX_IFACE_CTRL_ADDR, 8'h00);
        wr(CLK_DIR_ADDR, 8'h01);
        rd(STATUS_ADDR, 8'h05);
        wait_lvl(1'b0);
        wait_lvl(1'b1);
        check({7'h00, clk_oe}, 8'h01);
        wait_lvl(1'b0);
        check(8'(n), 8'(BASE_HALF_CYC));
        wait_lvl(1'b1);
        check(8'(n), 8'(BASE_HALF_CYC));
        wr(CLK_DIR_ADDR, 8'h00);
        repeat (3) tick();
        check({7'h00, clk_oe}, 8'h00);
        final_report();
    end
endmodule
